// File: include/slsts_regs.vh
`ifndef SLSTS_REGS_VH
`define SLSTS_REGS_VH

// Two-wire control port: 7-bit target address, arbitrary default
`define SLSTS_I2C_ADDR        7'h2C

// Register offsets
`define SLSTS_REG_CTRL        8'h24
`define SLSTS_REG_ERRCNT      8'h25

// Reset values and control write mask
`define SLSTS_CTRL_RESET      8'h00
`define SLSTS_ERRCNT_RESET    8'h00
`define SLSTS_CTRL_WMASK      8'h0F

// Control register field positions
`define SLSTS_CTRL_REGMODE    0
`define SLSTS_CTRL_EN         1
`define SLSTS_CTRL_CLKSEL_LO  2
`define SLSTS_CTRL_CLKSEL_HI  3

// Test clock source codes
`define SLSTS_CLKSEL_EXT      2'h0
`define SLSTS_CLKSEL_50M      2'h1
`define SLSTS_CLKSEL_25M      2'h2
`define SLSTS_CLKSEL_12M5     2'h3

// Timing
`define SLSTS_CLK_PERIOD_NS   100
`define SLSTS_WAKE_RETRY_NS   100000
`define SLSTS_WAKE_RETRY_CYC  (`SLSTS_WAKE_RETRY_NS / `SLSTS_CLK_PERIOD_NS)
`define SLSTS_PASS_LOW_CYC    4'h1
`define SLSTS_PASS_GAP_CYC    4'h1

`endif

// File: rtl/slsts_skid_buf.v
`timescale 1ns/1ps
module slsts_skid_buf #(
  parameter WIDTH = 13,
  parameter DEPTH = 2
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire             in_valid_in,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             in_ready_out,
  output wire             out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input  wire             out_ready_in
);
  localparam [1:0] DEPTH_C = DEPTH[1:0];

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg             wr_q;
  reg             rd_q;
  reg [1:0]       cnt_q;
  reg [1:0]       cnt_d;
  reg             ready_q;
  reg             valid_q;
  wire            push;
  wire            pop;

  assign push          = in_valid_in & ready_q;
  assign pop           = valid_q & out_ready_in;
  assign in_ready_out  = ready_q;
  assign out_valid_out = valid_q;
  assign out_data_out  = mem_q[rd_q];

  always @* begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      cnt_q   <= 2'h0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_in;
        wr_q        <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != DEPTH_C);
      valid_q <= (cnt_d != 2'h0);
    end
  end
endmodule // slsts_skid_buf

// File: rtl/slsts_pass_pulse.v
`timescale 1ns/1ps
`include "slsts_regs.vh"
module slsts_pass_pulse #(
  parameter [3:0] LOW_CYC = `SLSTS_PASS_LOW_CYC,
  parameter [3:0] GAP_CYC = `SLSTS_PASS_GAP_CYC
) (
  input  wire clk_in,
  input  wire rst_in,
  input  wire fire_in,
  output wire ready_out,
  output wire low_out
);
  reg [3:0] cnt_q;
  reg       low_q;
  reg       busy_q;

  assign ready_out = ~busy_q;
  assign low_out   = low_q;

  // Gap after each low keeps back-to-back errored frames countable
  always @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q  <= 4'h0;
      low_q  <= 1'b0;
      busy_q <= 1'b0;
    end else if (fire_in && !busy_q) begin
      low_q  <= 1'b1;
      busy_q <= 1'b1;
      cnt_q  <= LOW_CYC - 4'h1;
    end else if (busy_q) begin
      if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (low_q) begin
        low_q <= 1'b0;
        cnt_q <= GAP_CYC - 4'h1;
      end else begin
        busy_q <= 1'b0;
      end
    end
  end
endmodule // slsts_pass_pulse

// File: rtl/slsts_sequencer.v
`timescale 1ns/1ps
`include "slsts_regs.vh"
// Summary of operation
// - Enable pin high starts self-test and puts the serializer into test too.
// - Select code 00 external clock, 01 50 MHz, 10 25 MHz, 11 12.5 MHz.
// - Pins control test by default; control register takes over when chosen.
// - Sleeping serializer is woken by a back-channel command first.
// - Serializer sends the switching pattern; deserializer expects it.
// - Both in test and locked: pass pin goes high, checking begins.
// - Each frame with payload errors drives the pass pin low briefly, then high.
// - Every errored frame gives its own separate countable low pulse.
// - Enable pin low ends the test; checking stops.
// - Pass pin need not keep the final result after the test.
// - Errored frames are counted in a readable register kept after test.
// - Error count is read over the two-wire control port.
// - After the test the link returns to normal video transport.
module slsts_sequencer #(
  parameter DW        = 12,
  parameter WAKE_CYC  = `SLSTS_WAKE_RETRY_CYC,
  parameter [6:0] DEV_ADDR = `SLSTS_I2C_ADDR
) (
  input  wire          clk_in,
  input  wire          rst_in,
  input  wire          selftest_enable_pin_in,
  input  wire          test_clock_select_lo_in,
  input  wire          test_clock_select_hi_in,
  input  wire          lock_in,
  input  wire          ser_awake_in,
  input  wire          ser_test_ack_in,
  input  wire          rx_valid_in,
  input  wire [DW-1:0] rx_data_in,
  input  wire          rx_frame_end_in,
  output wire          rx_ready_out,
  input  wire          scl_in,
  input  wire          sda_in,
  output wire          sda_out,
  output wire          sda_oe_n_out,
  output wire          pass_out,
  output wire          bc_wake_out,
  output wire          ser_test_req_out,
  output wire [1:0]    test_clock_sel_out,
  output wire          int_osc_en_out,
  output wire          video_valid_out,
  output wire [DW-1:0] video_data_out,
  output wire          video_frame_end_out
);
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_WAKE  = 3'h1;
  localparam [2:0] S_ENTER = 3'h2;
  localparam [2:0] S_LOCK  = 3'h3;
  localparam [2:0] S_CHECK = 3'h4;
  localparam [2:0] S_EXIT  = 3'h5;

  localparam [2:0] I_IDLE  = 3'h0;
  localparam [2:0] I_ADDR  = 3'h1;
  localparam [2:0] I_AACK  = 3'h2;
  localparam [2:0] I_PTR   = 3'h3;
  localparam [2:0] I_WACK  = 3'h4;
  localparam [2:0] I_WDATA = 3'h5;
  localparam [2:0] I_RDATA = 3'h6;
  localparam [2:0] I_RACK  = 3'h7;

  localparam integer WAKE_M1_I = WAKE_CYC - 1;
  localparam [15:0]  WAKE_M1   = WAKE_M1_I[15:0];

  // Sequencer state
  reg [2:0]    st_q;
  reg [15:0]   tmr_q;
  reg          wake_q;
  reg          req_q;
  reg          pass_lvl_q;
  reg          pass_q;
  reg [1:0]    csel_q;
  reg          osc_q;
  reg [7:0]    errcnt_q;
  reg [7:0]    ctrl_q;

  // Checker state
  reg          synced_q;
  reg [DW-1:0] expect_q;
  reg          frm_err_q;

  // Video path
  reg          vvalid_q;
  reg [DW-1:0] vdata_q;
  reg          vend_q;

  // Two-wire slave state
  reg [2:0]    ist_q;
  reg          scl_q;
  reg          sda_q;
  reg [7:0]    sh_q;
  reg [3:0]    bc_q;
  reg [7:0]    ptr_q;
  reg          rw_q;
  reg          nack_q;
  reg          oe_n_q;
  reg          sda_o_q;
  reg [7:0]    rd_byte;

  wire          en;
  wire [1:0]    csel;
  wire          buf_valid;
  wire [DW:0]   buf_data;
  wire          buf_ready;
  wire          buf_in_ready;
  wire          pulse_ready;
  wire          pulse_low;
  wire          word_ok;
  wire          word_end;
  wire          take_check;
  wire          fire;
  wire          scl_rise;
  wire          scl_fall;
  wire          i_start;
  wire          i_stop;
  wire          reg_wr;

  // Register mode overrides pins only when software selects it
  assign en   = ctrl_q[`SLSTS_CTRL_REGMODE] ? ctrl_q[`SLSTS_CTRL_EN] :
                selftest_enable_pin_in;
  assign csel = ctrl_q[`SLSTS_CTRL_REGMODE] ?
                {ctrl_q[`SLSTS_CTRL_CLKSEL_HI], ctrl_q[`SLSTS_CTRL_CLKSEL_LO]} :
                {test_clock_select_hi_in, test_clock_select_lo_in};

  slsts_skid_buf #(
    .WIDTH (DW + 1),
    .DEPTH (2)
  ) u_buf (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (rx_valid_in),
    .in_data_in    ({rx_frame_end_in, rx_data_in}),
    .in_ready_out  (buf_in_ready),
    .out_valid_out (buf_valid),
    .out_data_out  (buf_data),
    .out_ready_in  (buf_ready)
  );

  slsts_pass_pulse u_pulse (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .fire_in   (fire),
    .ready_out (pulse_ready),
    .low_out   (pulse_low)
  );

  // Frame end waits for the pulse generator so no pulse is merged
  assign buf_ready  = !(st_q == S_CHECK && buf_data[DW] && !pulse_ready);
  assign take_check = (st_q == S_CHECK) && lock_in && buf_valid &&
                      buf_ready;
  assign word_ok    = !synced_q || (buf_data[DW-1:0] == expect_q);
  assign word_end   = buf_data[DW];
  assign fire       = take_check && word_end && (frm_err_q || !word_ok);

  always @(posedge clk_in) begin
    if (rst_in) begin
      synced_q  <= 1'b0;
      expect_q  <= {DW{1'b0}};
      frm_err_q <= 1'b0;
    end else if (take_check) begin
      // Pattern inverts every bit from one word to the next
      synced_q  <= 1'b1;
      expect_q  <= ~buf_data[DW-1:0];
      frm_err_q <= word_end ? 1'b0 : (frm_err_q || !word_ok);
    end else if (st_q != S_CHECK || !lock_in) begin
      // Partial frame across a lock loss is dropped, not judged
      synced_q  <= 1'b0;
      frm_err_q <= 1'b0;
    end
  end

  // Normal transport only outside a test session
  always @(posedge clk_in) begin
    if (rst_in) begin
      vvalid_q <= 1'b0;
      vdata_q  <= {DW{1'b0}};
      vend_q   <= 1'b0;
    end else begin
      vvalid_q <= (st_q == S_IDLE) && buf_valid;
      if ((st_q == S_IDLE) && buf_valid) begin
        vdata_q <= buf_data[DW-1:0];
        vend_q  <= buf_data[DW];
      end
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      st_q       <= S_IDLE;
      tmr_q      <= 16'h0000;
      wake_q     <= 1'b0;
      req_q      <= 1'b0;
      pass_lvl_q <= 1'b0;
      pass_q     <= 1'b0;
      csel_q     <= `SLSTS_CLKSEL_EXT;
      osc_q      <= 1'b0;
      errcnt_q   <= `SLSTS_ERRCNT_RESET;
    end else begin
      wake_q <= 1'b0;
      pass_q <= pass_lvl_q && !pulse_low;
      csel_q <= csel;
      osc_q  <= (st_q != S_IDLE) && (csel != `SLSTS_CLKSEL_EXT);
      if (fire && errcnt_q != 8'hFF) begin
        errcnt_q <= errcnt_q + 8'h01;
      end
      case (st_q)
        S_IDLE: begin
          if (en) begin
            errcnt_q <= `SLSTS_ERRCNT_RESET;
            tmr_q    <= WAKE_M1;
            if (ser_awake_in) begin
              st_q <= S_ENTER;
            end else begin
              wake_q <= 1'b1;
              st_q   <= S_WAKE;
            end
          end
        end
        S_WAKE: begin
          if (!en) begin
            st_q <= S_EXIT;
          end else if (ser_awake_in) begin
            st_q <= S_ENTER;
          end else if (tmr_q == 16'h0000) begin
            // Command may be lost while the far end powers up
            wake_q <= 1'b1;
            tmr_q  <= WAKE_M1;
          end else begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        S_ENTER: begin
          req_q <= 1'b1;
          if (!en) begin
            st_q <= S_EXIT;
          end else if (ser_test_ack_in) begin
            st_q <= S_LOCK;
          end
        end
        S_LOCK: begin
          if (!en) begin
            st_q <= S_EXIT;
          end else if (lock_in && ser_test_ack_in) begin
            pass_lvl_q <= 1'b1;
            st_q       <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (!en) begin
            st_q <= S_EXIT;
          end else if (!lock_in) begin
            st_q <= S_LOCK;
          end
        end
        S_EXIT: begin
          req_q      <= 1'b0;
          pass_lvl_q <= 1'b0;
          if (!ser_test_ack_in) begin
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // Two-wire slave; inputs are sampled on the system clock
  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign i_start  = scl_in && scl_q && sda_q && !sda_in;
  assign i_stop   = scl_in && scl_q && !sda_q && sda_in;
  assign reg_wr   = scl_fall && (ist_q == I_WDATA) && (bc_q == 4'h8) &&
                    (ptr_q == `SLSTS_REG_CTRL);

  always @* begin
    rd_byte = 8'h00;
    if (ptr_q == `SLSTS_REG_CTRL) begin
      rd_byte = ctrl_q;
    end else if (ptr_q == `SLSTS_REG_ERRCNT) begin
      rd_byte = errcnt_q;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_q <= `SLSTS_CTRL_RESET;
    end else if (reg_wr) begin
      ctrl_q <= sh_q & `SLSTS_CTRL_WMASK;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      ist_q   <= I_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      sh_q    <= 8'h00;
      bc_q    <= 4'h0;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
      oe_n_q  <= 1'b1;
      sda_o_q <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (i_start) begin
        ist_q  <= I_ADDR;
        bc_q   <= 4'h0;
        oe_n_q <= 1'b1;
      end else if (i_stop) begin
        ist_q  <= I_IDLE;
        oe_n_q <= 1'b1;
      end else if (scl_rise) begin
        if (ist_q == I_ADDR || ist_q == I_PTR || ist_q == I_WDATA) begin
          sh_q <= {sh_q[6:0], sda_in};
          bc_q <= bc_q + 4'h1;
        end else if (ist_q == I_RACK) begin
          nack_q <= sda_in;
        end
      end else if (scl_fall) begin
        case (ist_q)
          I_ADDR: begin
            if (bc_q == 4'h8) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                rw_q   <= sh_q[0];
                oe_n_q <= 1'b0;
                ist_q  <= I_AACK;
              end else begin
                ist_q <= I_IDLE;
              end
            end
          end
          I_AACK: begin
            bc_q <= 4'h1;
            if (rw_q) begin
              sh_q   <= {rd_byte[6:0], 1'b0};
              oe_n_q <= rd_byte[7];
              ist_q  <= I_RDATA;
            end else begin
              bc_q   <= 4'h0;
              oe_n_q <= 1'b1;
              ist_q  <= I_PTR;
            end
          end
          I_PTR: begin
            if (bc_q == 4'h8) begin
              ptr_q  <= sh_q;
              oe_n_q <= 1'b0;
              ist_q  <= I_WACK;
            end
          end
          I_WDATA: begin
            if (bc_q == 4'h8) begin
              ptr_q  <= ptr_q + 8'h01;
              oe_n_q <= 1'b0;
              ist_q  <= I_WACK;
            end
          end
          I_WACK: begin
            bc_q   <= 4'h0;
            oe_n_q <= 1'b1;
            ist_q  <= I_WDATA;
          end
          I_RDATA: begin
            if (bc_q == 4'h8) begin
              oe_n_q <= 1'b1;
              ptr_q  <= ptr_q + 8'h01;
              ist_q  <= I_RACK;
            end else begin
              oe_n_q <= sh_q[7];
              sh_q   <= {sh_q[6:0], 1'b0};
              bc_q   <= bc_q + 4'h1;
            end
          end
          I_RACK: begin
            if (!nack_q) begin
              sh_q   <= {rd_byte[6:0], 1'b0};
              oe_n_q <= rd_byte[7];
              bc_q   <= 4'h1;
              ist_q  <= I_RDATA;
            end else begin
              ist_q <= I_IDLE;
            end
          end
          default: begin
            oe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end

  assign rx_ready_out        = buf_in_ready;
  assign sda_out             = sda_o_q;
  assign sda_oe_n_out        = oe_n_q;
  assign pass_out            = pass_q;
  assign bc_wake_out         = wake_q;
  assign ser_test_req_out    = req_q;
  assign test_clock_sel_out  = csel_q;
  assign int_osc_en_out      = osc_q;
  assign video_valid_out     = vvalid_q;
  assign video_data_out      = vdata_q;
  assign video_frame_end_out = vend_q;
endmodule // slsts_sequencer

// File: dv/slsts_props.sv
`timescale 1ns/1ps
module slsts_props #(
  parameter DW       = 12,
  parameter WAKE_CYC = 8
) (
  input wire       clk_in,
  input wire       rst_in,
  input wire       selftest_enable_pin_in,
  input wire       test_clock_select_lo_in,
  input wire       test_clock_select_hi_in,
  input wire       lock_in,
  input wire       ser_awake_in,
  input wire       ser_test_ack_in,
  input wire       pass_out,
  input wire       bc_wake_out,
  input wire       ser_test_req_out,
  input wire [1:0] test_clock_sel_out,
  input wire       int_osc_en_out,
  input wire       video_valid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reg [15:0] wake_gap_q;
  reg        wake_seen_q;
  // Cycles since the last wake command, for the retry spacing
  always @(posedge clk_in) begin
    if (rst_in) begin
      wake_gap_q  <= 16'h0000;
      wake_seen_q <= 1'h0;
    end else begin
      wake_gap_q  <= bc_wake_out ? 16'h0001 : wake_gap_q + 16'h0001;
      wake_seen_q <= wake_seen_q | bc_wake_out;
    end
  end
  sequence in_test_s;
    selftest_enable_pin_in && $past(selftest_enable_pin_in);
  endsequence
  sequence err_pulse_s;
    $fell(pass_out) ##1 pass_out;
  endsequence
  // Margin for a low pulse already started before lock fell
  sequence unlocked_s;
    (!lock_in && selftest_enable_pin_in) [*6];
  endsequence
  a_pass_pulse_one: assert property (
    in_test_s ##0 $fell(pass_out) |-> err_pulse_s)
    else $error("pass low pulse not one cycle");
  a_no_pulse_unlock: assert property (
    unlocked_s |-> !$fell(pass_out))
    else $error("pass pulse without lock");
  a_pass_rise_cause: assert property (
    $rose(pass_out) |-> ser_test_ack_in && $past(lock_in))
    else $error("pass rose without ack and lock");
  a_req_when_awake: assert property (
    $rose(ser_test_req_out) |-> $past(ser_awake_in))
    else $error("test request to sleeping serializer");
  a_wake_when_asleep: assert property (
    bc_wake_out |-> !$past(ser_awake_in))
    else $error("wake sent to awake serializer");
  a_wake_retry_gap: assert property (
    bc_wake_out && wake_seen_q |-> wake_gap_q == WAKE_CYC)
    else $error("wake retry spacing wrong");
  a_clksel_pins: assert property (
    in_test_s ##0 ser_test_req_out |-> test_clock_sel_out ==
      {$past(test_clock_select_hi_in), $past(test_clock_select_lo_in)})
    else $error("clock select does not follow pins");
  a_osc_by_code: assert property (
    int_osc_en_out |-> test_clock_sel_out != 2'h0)
    else $error("oscillator on for external code");
  a_video_quiet: assert property (
    ser_test_req_out |-> !video_valid_out)
    else $error("video forwarded during test");
endmodule // slsts_props

bind slsts_sequencer slsts_props #(
  .DW       (DW),
  .WAKE_CYC (WAKE_CYC)
) i_slsts_props (
  .clk_in                  (clk_in),
  .rst_in                  (rst_in),
  .selftest_enable_pin_in  (selftest_enable_pin_in),
  .test_clock_select_lo_in (test_clock_select_lo_in),
  .test_clock_select_hi_in (test_clock_select_hi_in),
  .lock_in                 (lock_in),
  .ser_awake_in            (ser_awake_in),
  .ser_test_ack_in         (ser_test_ack_in),
  .pass_out                (pass_out),
  .bc_wake_out             (bc_wake_out),
  .ser_test_req_out        (ser_test_req_out),
  .test_clock_sel_out      (test_clock_sel_out),
  .int_osc_en_out          (int_osc_en_out),
  .video_valid_out         (video_valid_out)
);

// File: dv/slsts_ser_model.sv
`timescale 1ns/1ps
module slsts_ser_model (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        bc_wake_in,
  input  wire        test_req_in,
  input  wire        lock_en_in,
  input  wire        err_in,
  input  wire        ready_in,
  output reg         awake_out,
  output reg         test_ack_out,
  output wire        lock_out,
  output reg         valid_out,
  output reg  [11:0] data_out,
  output reg         frame_end_out,
  output reg  [15:0] err_frames_out
);
  reg [3:0]  wake_q;
  reg [1:0]  idx_q;
  reg [11:0] pat_q;
  reg [11:0] vid_q;
  assign lock_out = lock_en_in & awake_out;
  always @(posedge clk_in) begin
    if (rst_in) begin
      awake_out      <= 1'h0;
      test_ack_out   <= 1'h0;
      valid_out      <= 1'h0;
      frame_end_out  <= 1'h0;
      err_frames_out <= 16'h0000;
      wake_q         <= 4'h0;
      idx_q          <= 2'h0;
      pat_q          <= 12'hA5A;
      vid_q          <= 12'h000;
    end else begin
      // Slower than one retry period, so the command must repeat
      if (bc_wake_in && wake_q == 4'h0)
        wake_q <= 4'h1;
      else if (wake_q != 4'h0 && !awake_out)
        wake_q <= wake_q + 4'h1;
      awake_out    <= awake_out | (wake_q == 4'hB);
      test_ack_out <= test_req_in & awake_out;
      if (!valid_out || ready_in) begin
        valid_out     <= awake_out;
        idx_q         <= idx_q + 2'h1;
        frame_end_out <= idx_q == 2'h3;
        pat_q         <= ~pat_q;
        vid_q         <= vid_q + 12'h001;
        if (!awake_out)
          data_out <= ~data_out;
        else if (!test_ack_out)
          data_out <= vid_q;
        else if (err_in && idx_q == 2'h1)
          data_out <= ~pat_q ^ 12'h001;
        else
          data_out <= ~pat_q;
        if (test_ack_out && err_in && idx_q == 2'h1 && lock_en_in)
          err_frames_out <= err_frames_out + 16'h0001;
      end
    end
  end
endmodule // slsts_ser_model

// File: dv/testbench.sv
`timescale 1ns/1ps
`include "slsts_regs.vh"
module testbench;
  reg         clk_in = 1'h0;
  reg         rst_in = 1'h1;
  reg         en_q = 1'h0, lo_q = 1'h0, hi_q = 1'h0;
  reg         lock_q = 1'h1, err_q = 1'h0, scl_q = 1'h1, sda_q = 1'h1;
  reg         pass_prev = 1'h0;
  reg  [11:0] vid_last = 12'h000;
  wire        sda_out, sda_oe_n_out, pass_out, bc_wake_out, req, ack;
  wire        awake, lock, rx_valid, rx_fe, rx_ready, int_osc_en_out;
  wire        video_valid_out, vid_fe;
  wire [11:0] rx_data, vid_data;
  wire [1:0]  test_clock_sel_out;
  wire [15:0] ser_errs;
  wire        sda_in = sda_q & (sda_oe_n_out | sda_out);
  integer     n_errors = 0, checks = 0, n_fall = 0, wakes = 0, vid_n = 0;
  integer     fe_bad = 0;

  always #50 clk_in = ~clk_in;

  slsts_sequencer #(.DW(12), .WAKE_CYC(8)) i_slsts_sequencer (
    .clk_in(clk_in), .rst_in(rst_in), .selftest_enable_pin_in(en_q),
    .test_clock_select_lo_in(lo_q), .test_clock_select_hi_in(hi_q),
    .lock_in(lock), .ser_awake_in(awake), .ser_test_ack_in(ack),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data),
    .rx_frame_end_in(rx_fe), .rx_ready_out(rx_ready),
    .scl_in(scl_q), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out), .pass_out(pass_out),
    .bc_wake_out(bc_wake_out), .ser_test_req_out(req),
    .test_clock_sel_out(test_clock_sel_out),
    .int_osc_en_out(int_osc_en_out), .video_valid_out(video_valid_out),
    .video_data_out(vid_data), .video_frame_end_out(vid_fe));

  slsts_ser_model i_slsts_ser_model (
    .clk_in(clk_in), .rst_in(rst_in), .bc_wake_in(bc_wake_out),
    .test_req_in(req), .lock_en_in(lock_q), .err_in(err_q),
    .ready_in(rx_ready), .awake_out(awake), .test_ack_out(ack),
    .lock_out(lock), .valid_out(rx_valid), .data_out(rx_data),
    .frame_end_out(rx_fe), .err_frames_out(ser_errs));

  // Host side pulse counter and stream watch
  always @(negedge clk_in) begin
    if (pass_prev && !pass_out)
      n_fall = n_fall + 1;
    pass_prev = pass_out;
    if (bc_wake_out)
      wakes = wakes + 1;
    if (video_valid_out) begin
      vid_n = vid_n + 1;
      vid_last = vid_data;
      // Partner marks the word whose low two count bits are 3
      if (vid_fe !== (vid_data[1:0] == 2'h3))
        fe_bad = fe_bad + 1;
    end
  end

  task summarize;
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input [15:0] got, input [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task tk(input integer n);
    repeat (n) @(posedge clk_in);
  endtask

  task ibit(input b, output r);
    sda_q <= b;
    tk(4);
    scl_q <= 1'h1;
    tk(4);
    @(negedge clk_in) r = sda_in;
    @(posedge clk_in) scl_q <= 1'h0;
    tk(1);
  endtask

  task ibyte(input [8:0] d, output [8:0] r);
    integer i;
    for (i = 8; i >= 0; i = i - 1)
      ibit(d[i], r[i]);
  endtask

  // Also serves as repeated start: SDA is raised while SCL is low
  task istart;
    sda_q <= 1'h1;
    tk(4);
    scl_q <= 1'h1;
    tk(4);
    sda_q <= 1'h0;
    tk(4);
    scl_q <= 1'h0;
    tk(1);
  endtask

  task istop;
    sda_q <= 1'h0;
    tk(4);
    scl_q <= 1'h1;
    tk(4);
    sda_q <= 1'h1;
    tk(4);
  endtask

  task reg_wr(input [7:0] a, input [7:0] v);
    reg [8:0] r;
    tk(1);
    istart;
    ibyte({`SLSTS_I2C_ADDR, 1'h0, 1'h1}, r);
    chk(r[0], 1'h0);
    ibyte({a, 1'h1}, r);
    ibyte({v, 1'h1}, r);
    chk(r[0], 1'h0);
    istop;
  endtask

  task reg_rd(input [7:0] a, output [7:0] v);
    reg [8:0] r;
    tk(1);
    istart;
    ibyte({`SLSTS_I2C_ADDR, 1'h0, 1'h1}, r);
    ibyte({a, 1'h1}, r);
    istart;
    ibyte({`SLSTS_I2C_ADDR, 1'h1, 1'h1}, r);
    chk(r[0], 1'h0);
    ibyte(9'h1FF, r);
    v = r[8:1];
    istop;
  endtask

  task wait_pass;
    integer k;
    k = 0;
    while (pass_out !== 1'h1 && k < 400) begin
      @(negedge clk_in);
      k = k + 1;
    end
    chk(pass_out, 1'h1);
  endtask

  task sess_on(input [1:0] c);
    tk(1);
    lo_q <= c[0];
    hi_q <= c[1];
    en_q <= 1'h1;
    wait_pass;
    chk(test_clock_sel_out, c);
    chk(int_osc_en_out, c != 2'h0);
  endtask

  task sess_off;
    integer   n0;
    reg [11:0] a, d;
    tk(1);
    en_q <= 1'h0;
    tk(30);
    @(negedge clk_in);
    chk(req, 1'h0);
    chk(pass_out, 1'h0);
    chk(rx_ready, 1'h1);
    n0 = vid_n;
    a = vid_last;
    tk(20);
    d = vid_last - a;
    chk(d, vid_n - n0);
    chk(vid_n > n0, 1'h1);
    chk(fe_bad, 16'h0000);
  endtask

  // Errors while unlocked, then relock: no pulses, tally kept
  task sc_first;
    reg [15:0] e0;
    reg [7:0]  v;
    sess_on(2'h2);
    chk(wakes, 16'h0002);
    n_fall = 0;
    e0 = ser_errs;
    tk(1);
    err_q <= 1'h1;
    tk(40);
    err_q <= 1'h0;
    tk(40);
    e0 = ser_errs - e0;
    chk(n_fall, e0);
    chk(e0 > 16'h0001, 1'h1);
    reg_rd(`SLSTS_REG_ERRCNT, v);
    chk(v, e0[7:0]);
    lock_q <= 1'h0;
    tk(10);
    err_q <= 1'h1;
    tk(40);
    err_q <= 1'h0;
    tk(40);
    lock_q <= 1'h1;
    tk(40);
    chk(n_fall, e0);
    sess_off;
    reg_rd(`SLSTS_REG_ERRCNT, v);
    chk(v, e0[7:0]);
  endtask

  task sc_codes;
    integer   c;
    reg [7:0] v;
    for (c = 0; c < 4; c = c + 1) begin
      sess_on(c[1:0]);
      sess_off;
    end
    reg_rd(`SLSTS_REG_ERRCNT, v);
    chk(v, 8'h00);
  endtask

  task sc_regmode;
    reg [7:0] v;
    reg_wr(`SLSTS_REG_CTRL, 8'h07);
    wait_pass;
    chk(test_clock_sel_out, 2'h1);
    reg_rd(`SLSTS_REG_CTRL, v);
    chk(v, 8'h07);
    reg_wr(`SLSTS_REG_ERRCNT, 8'h55);
    reg_rd(`SLSTS_REG_ERRCNT, v);
    chk(v, 8'h00);
    reg_rd(8'h30, v);
    chk(v, 8'h00);
    reg_wr(`SLSTS_REG_CTRL, 8'h00);
    tk(30);
    @(negedge clk_in);
    chk(req, 1'h0);
  endtask

  task sc_saturate;
    reg [15:0] e0;
    reg [7:0]  v;
    sess_on(2'h3);
    n_fall = 0;
    e0 = ser_errs;
    tk(1);
    err_q <= 1'h1;
    tk(2600);
    err_q <= 1'h0;
    tk(40);
    e0 = ser_errs - e0;
    chk(n_fall, e0);
    chk(e0 > 16'h00FF, 1'h1);
    reg_rd(`SLSTS_REG_ERRCNT, v);
    chk(v, 8'hFF);
    sess_off;
  endtask

  initial begin
    tk(12);
    rst_in <= 1'h0;
    sc_first;
    sc_codes;
    sc_regmode;
    sc_saturate;
    summarize;
  end

  // Roughly eight times the expected run
  initial begin
    #6000000;
    n_errors = n_errors + 1;
    summarize;
  end
endmodule // testbench
